// [logic/cmpctl_top.sv]
/*
 * Control and status registers of two voltage comparators on the SFR bus.
 * Assumes a synchronous SFR bus on core_clk; raw comparator outputs are
 * asynchronous and the analog macros take the settings driven here.
 */
// Overview of operation
// - A comparator compares nothing until software sets its enable bit.
// - Clearing the enable bit shuts the comparator down to low power.
// - Control bit 6 reads the synchronised comparator output, read only.
// - Control bit 5 is a sticky rising-edge flag cleared by software.
// - Control bit 4 is a sticky falling-edge flag cleared by software.
// - Bits 3:2 select positive hysteresis: off, 5, 10, 20 mV.
// - Bits 1:0 select negative hysteresis: off, 5, 10, 20 mV.
// - Mode bit 5 enables the rising-edge interrupt.
// - Mode bit 4 enables the falling-edge interrupt.
// - Mode bits 1:0 pick response time, 00 fastest, 11 lowest power.
// - Mode bit 7 always reads 1; software writes 1 there.
// - Mode bits 6 and 3:2 read 0 and ignore writes.
// - The second comparator has its own control register, same layout.
// - A disabled comparator's output is held at 0.
// - Edge flags set whatever the interrupt enables say.
// - Raw comparator output is synchronised before state bit and edges.
`timescale 1ns/100ps
`default_nettype none
`include "cmpctl_regs.svh"

module cmpctl_top
(
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    // SFR bus
    input  wire cmpctl_pkg::cmpctl_sfr_req_t sfr_req,
    output var  logic [7:0]                  sfr_rdata,
    // Raw comparator outputs
    input  wire logic                        cmp_a_raw,
    input  wire logic                        cmp_b_raw,
    // Analog settings
    output var  cmpctl_pkg::cmpctl_ctrl_t    cmp_a_ctrl,
    output var  cmpctl_pkg::cmpctl_ctrl_t    cmp_b_ctrl,
    output var  cmpctl_pkg::cmpctl_mode_t    cmp_a_mode,
    // Synchronised outputs and interrupt
    output var  logic                        cmp_a_sync_out,
    output var  logic                        cmp_b_sync_out,
    output var  logic                        cmp_irq
);

    import cmpctl_pkg::*;

    cmpctl_ctrl_t ctrl_a_reg;
    cmpctl_ctrl_t ctrl_b_reg;
    cmpctl_mode_t mode_a_reg;
    logic         rise_a;
    logic         fall_a;
    logic         rise_b;
    logic         fall_b;
    logic         wr_ctrl_a;
    logic         wr_ctrl_b;
    logic         wr_mode_a;
    logic [7:0]   rdata_next;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    function automatic logic [7:0] ctrl_read(input cmpctl_ctrl_t c, input logic o,
                                             input logic r, input logic f);
        ctrl_read = {c.enable, o, r, f, c.pos_hysteresis, c.neg_hysteresis};
    endfunction : ctrl_read

    function automatic cmpctl_ctrl_t ctrl_write(input logic [7:0] d);
        ctrl_write.enable         = d[`CMPCTL_CTRL_EN];
        ctrl_write.pos_hysteresis = d[`CMPCTL_CTRL_HYP_HI:`CMPCTL_CTRL_HYP_LO];
        ctrl_write.neg_hysteresis = d[`CMPCTL_CTRL_HYN_HI:`CMPCTL_CTRL_HYN_LO];
    endfunction : ctrl_write

    assign wr_ctrl_a = sfr_req.wr & addr_hit(sfr_req.addr, `CMPCTL_ADDR_CTRL_A);
    assign wr_ctrl_b = sfr_req.wr & addr_hit(sfr_req.addr, `CMPCTL_ADDR_CTRL_B);
    assign wr_mode_a = sfr_req.wr & addr_hit(sfr_req.addr, `CMPCTL_ADDR_MODE_A);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ctrl_a_reg <= ctrl_write(`CMPCTL_RST_CTRL);
        else if (wr_ctrl_a)
            ctrl_a_reg <= ctrl_write(sfr_req.wdata);
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ctrl_b_reg <= ctrl_write(`CMPCTL_RST_CTRL);
        else if (wr_ctrl_b)
            ctrl_b_reg <= ctrl_write(sfr_req.wdata);
    end

    // Reserved and unused mode bits are not stored
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_a_reg.rise_irq_enable <= 1'b0;
            mode_a_reg.fall_irq_enable <= 1'b0;
            mode_a_reg.response_mode   <= CMPCTL_RESP_MID2;
        end
        else if (wr_mode_a)
        begin
            mode_a_reg.rise_irq_enable <= sfr_req.wdata[`CMPCTL_MODE_RIE];
            mode_a_reg.fall_irq_enable <= sfr_req.wdata[`CMPCTL_MODE_FIE];
            mode_a_reg.response_mode   <= cmpctl_resp_t'(
                sfr_req.wdata[`CMPCTL_MODE_RESP_HI:`CMPCTL_MODE_RESP_LO]);
        end
    end

    // Enable low puts the analog macro into shutdown
    assign cmp_a_ctrl = ctrl_a_reg;
    assign cmp_b_ctrl = ctrl_b_reg;
    assign cmp_a_mode = mode_a_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Channels; flags set regardless of interrupt enables
    cmpctl_chan u_chan_a
    (
        .core_clk        (core_clk),
        .reset           (reset),
        .raw_out         (cmp_a_raw),
        .enable          (ctrl_a_reg.enable),
        .flag_wr         (wr_ctrl_a),
        .flag_wdata_rise (sfr_req.wdata[`CMPCTL_CTRL_RISE]),
        .flag_wdata_fall (sfr_req.wdata[`CMPCTL_CTRL_FALL]),
        .out_state       (cmp_a_sync_out),
        .rise_flag       (rise_a),
        .fall_flag       (fall_a)
    );

    cmpctl_chan u_chan_b
    (
        .core_clk        (core_clk),
        .reset           (reset),
        .raw_out         (cmp_b_raw),
        .enable          (ctrl_b_reg.enable),
        .flag_wr         (wr_ctrl_b),
        .flag_wdata_rise (sfr_req.wdata[`CMPCTL_CTRL_RISE]),
        .flag_wdata_fall (sfr_req.wdata[`CMPCTL_CTRL_FALL]),
        .out_state       (cmp_b_sync_out),
        .rise_flag       (rise_b),
        .fall_flag       (fall_b)
    );

    assign cmp_irq = (rise_a & mode_a_reg.rise_irq_enable)
                   | (fall_a & mode_a_reg.fall_irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe
    always_comb
    begin
        rdata_next = `CMPCTL_RDATA_UNMAPPED;
        if (addr_hit(sfr_req.addr, `CMPCTL_ADDR_CTRL_A))
            rdata_next = ctrl_read(ctrl_a_reg, cmp_a_sync_out, rise_a, fall_a);
        else if (addr_hit(sfr_req.addr, `CMPCTL_ADDR_CTRL_B))
            rdata_next = ctrl_read(ctrl_b_reg, cmp_b_sync_out, rise_b, fall_b);
        else if (addr_hit(sfr_req.addr, `CMPCTL_ADDR_MODE_A))
        begin
            rdata_next[`CMPCTL_MODE_RSVD]                         = 1'b1;
            rdata_next[`CMPCTL_MODE_RIE]                          = mode_a_reg.rise_irq_enable;
            rdata_next[`CMPCTL_MODE_FIE]                          = mode_a_reg.fall_irq_enable;
            rdata_next[`CMPCTL_MODE_RESP_HI:`CMPCTL_MODE_RESP_LO] = mode_a_reg.response_mode;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            sfr_rdata <= `CMPCTL_RDATA_UNMAPPED;
        else if (sfr_req.rd)
            sfr_rdata <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_SYNC_PATH: assert property (
        $past(reset, 3) == 1'b0 |->
            cmp_a_sync_out == ($past(ctrl_a_reg.enable) & $past(cmp_a_raw, 3)))
        else $error("Output state does not follow raw input three cycles later");

    AST_DISABLED_ZERO: assert property (
        !ctrl_a_reg.enable |=> !cmp_a_sync_out)
        else $error("Disabled comparator output not zero");

    AST_ENABLE_WRITE: assert property (
        wr_ctrl_a |=> ctrl_a_reg.enable == $past(sfr_req.wdata[`CMPCTL_CTRL_EN]))
        else $error("Enable bit did not take the written value");

    AST_RISE_SET: assert property (
        $rose(cmp_a_sync_out) |-> rise_a)
        else $error("Rising edge not flagged");

    AST_FALL_SET: assert property (
        $fell(cmp_b_sync_out) |-> fall_b)
        else $error("Falling edge not flagged");

    AST_RISE_STICKY: assert property (
        rise_a && !(wr_ctrl_a && !sfr_req.wdata[`CMPCTL_CTRL_RISE]) |=> rise_a)
        else $error("Rising flag lost without a clear");

    AST_MODE_READ: assert property (
        sfr_req.rd && addr_hit(sfr_req.addr, `CMPCTL_ADDR_MODE_A)
            |=> sfr_rdata[`CMPCTL_MODE_RSVD] && sfr_rdata[6] == 1'b0
                && sfr_rdata[3:2] == 2'h0)
        else $error("Mode register reserved or unused bits read wrong");

    AST_STATE_READ: assert property (
        sfr_req.rd && addr_hit(sfr_req.addr, `CMPCTL_ADDR_CTRL_A)
            |=> sfr_rdata[`CMPCTL_CTRL_OUT] == $past(cmp_a_sync_out))
        else $error("Output state bit read wrong");

    AST_IRQ: assert property (
        $rose(cmp_a_sync_out) && mode_a_reg.rise_irq_enable
            || $fell(cmp_a_sync_out) && mode_a_reg.fall_irq_enable
            |-> cmp_irq)
        else $error("Enabled output edge raised no interrupt request");

    AST_HYS_WRITE: assert property (
        wr_ctrl_b |=> cmp_b_ctrl.pos_hysteresis == $past(sfr_req.wdata[3:2])
                      && cmp_b_ctrl.neg_hysteresis == $past(sfr_req.wdata[1:0]))
        else $error("Hysteresis settings did not follow the write");

endmodule : cmpctl_top

`default_nettype wire

// [logic/cmpctl_regs.svh]
/*
 * Register map constants for the dual comparator control block.
 * Assumes an 8-bit special-function-register bus with 8-bit addresses.
 */
`ifndef CMPCTL_REGS_SVH
`define CMPCTL_REGS_SVH

// Register addresses
`define CMPCTL_ADDR_CTRL_B     8'h9a
`define CMPCTL_ADDR_CTRL_A     8'h9b
`define CMPCTL_ADDR_MODE_A     8'h9d

// Control register fields
`define CMPCTL_CTRL_EN         7
`define CMPCTL_CTRL_OUT        6
`define CMPCTL_CTRL_RISE       5
`define CMPCTL_CTRL_FALL       4
`define CMPCTL_CTRL_HYP_HI     3
`define CMPCTL_CTRL_HYP_LO     2
`define CMPCTL_CTRL_HYN_HI     1
`define CMPCTL_CTRL_HYN_LO     0

// Mode register fields
`define CMPCTL_MODE_RSVD       7
`define CMPCTL_MODE_RIE        5
`define CMPCTL_MODE_FIE        4
`define CMPCTL_MODE_RESP_HI    1
`define CMPCTL_MODE_RESP_LO    0

// Reset values
`define CMPCTL_RST_CTRL        8'h00
`define CMPCTL_RST_MODE        8'h82
`define CMPCTL_RDATA_UNMAPPED  8'h00

`endif

// [logic/cmpctl_pkg.sv]
/*
 * Types shared by the comparator control block.
 * Assumes cmpctl_regs.svh is on the include path.
 */
`default_nettype none

package cmpctl_pkg;

    // Response time codes, fastest first
    typedef enum logic [1:0] {
        CMPCTL_RESP_FAST = 2'h0,
        CMPCTL_RESP_MID1 = 2'h1,
        CMPCTL_RESP_MID2 = 2'h2,
        CMPCTL_RESP_SLOW = 2'h3
    } cmpctl_resp_t;

    // Settings driven to one analog comparator
    typedef struct packed {
        logic       enable;
        logic [1:0] pos_hysteresis;
        logic [1:0] neg_hysteresis;
    } cmpctl_ctrl_t;

    // Mode settings of the first comparator
    typedef struct packed {
        logic         rise_irq_enable;
        logic         fall_irq_enable;
        cmpctl_resp_t response_mode;
    } cmpctl_mode_t;

    // One bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmpctl_sfr_req_t;

endpackage : cmpctl_pkg

`default_nettype wire

// [logic/cmpctl_chan.sv]
/*
 * One comparator channel: synchroniser, enable gating, sticky edge flags.
 * Assumes raw is asynchronous to core_clk and flag writes come from the bus.
 */
`timescale 1ns/100ps
`default_nettype none

module cmpctl_chan
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Analog side
    input  wire logic raw_out,
    input  wire logic enable,
    // Flag write from the bus
    input  wire logic flag_wr,
    input  wire logic flag_wdata_rise,
    input  wire logic flag_wdata_fall,
    // State
    output var  logic out_state,
    output var  logic rise_flag,
    output var  logic fall_flag
);

    logic sync_1_reg;
    logic sync_2_reg;
    logic gated;
    logic rise_evt;
    logic fall_evt;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sync_1_reg <= 1'b0;
            sync_2_reg <= 1'b0;
        end
        else
        begin
            sync_1_reg <= raw_out;
            sync_2_reg <= sync_1_reg;
        end
    end

    // Disabled comparator reads as 0
    assign gated    = enable & sync_2_reg;
    assign rise_evt = gated & ~out_state;
    assign fall_evt = ~gated & out_state;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            out_state <= 1'b0;
        else
            out_state <= gated;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge wins over a simultaneous clear
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rise_flag <= 1'b0;
            fall_flag <= 1'b0;
        end
        else
        begin
            rise_flag <= rise_evt | (flag_wr ? flag_wdata_rise : rise_flag);
            fall_flag <= fall_evt | (flag_wr ? flag_wdata_fall : fall_flag);
        end
    end

endmodule : cmpctl_chan

`default_nettype wire

// [sim/cmpctl_tb.sv]
/*
 * Self-checking bench for the dual comparator control block: register access,
 * synchroniser timing, sticky edge flags and the interrupt request.
 * Assumes cmpctl_pkg is compiled first and cmpctl_regs.svh is on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cmpctl_regs.svh"

module testbench;
    import cmpctl_pkg::*;

    logic            core_clk;
    logic            reset;
    cmpctl_sfr_req_t sfr_req;
    logic [7:0]      sfr_rdata;
    logic            cmp_a_raw;
    logic            cmp_b_raw;
    cmpctl_ctrl_t    cmp_a_ctrl;
    cmpctl_ctrl_t    cmp_b_ctrl;
    cmpctl_mode_t    cmp_a_mode;
    logic            cmp_a_sync_out;
    logic            cmp_b_sync_out;
    logic            cmp_irq;
    logic            rd_d;
    logic [7:0]      exp_q[$];
    int              n_mismatch;
    int              tests_run;
    logic [1:0]      hy;
    logic [1:0]      rie_fie;
    logic            v;

    cmpctl_top i_cmpctl_top (
        .core_clk(core_clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .cmp_a_ctrl(cmp_a_ctrl),
        .cmp_b_ctrl(cmp_b_ctrl), .cmp_a_mode(cmp_a_mode), .cmp_a_sync_out(cmp_a_sync_out),
        .cmp_b_sync_out(cmp_b_sync_out), .cmp_irq(cmp_irq)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n

    // One strobe cycle, then one idle cycle so strobes never merge
    task automatic bus(input logic is_wr, input logic [7:0] addr, input logic [7:0] data);
        sfr_req = '{wr: is_wr, rd: ~is_wr, addr: addr, wdata: data};
        @(negedge core_clk);
        sfr_req = '0;
        @(negedge core_clk);
    endtask : bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        bus(1'b1, addr, data);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, addr, 8'h00);
    endtask : rd

    // Raw input of comparator A steps; output must lag by the synchroniser
    task automatic step_a(input logic val);
        cmp_a_raw = val;
        wait_n(2);
        check("sync_a_lag", {7'h0, cmp_a_sync_out}, {7'h0, ~val});
        wait_n(1);
        check("sync_a", {7'h0, cmp_a_sync_out}, {7'h0, val});
    endtask : step_a

    task automatic stop_test;
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    // Read data monitor

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rd_d <= 1'b0;
        else
            rd_d <= sfr_req.rd;
    end

    always @(negedge core_clk)
    begin
        if (rd_d === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                n_mismatch++;
                $display("MISMATCH sfr_rdata expected none seen %h", sfr_rdata);
            end
            else
                check("sfr_rdata", sfr_rdata, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence

    initial
    begin
        sfr_req = '0;
        cmp_a_raw = 1'b0;
        cmp_b_raw = 1'b0;
        reset = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        v = 1'($urandom(12583));
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        // Reset values and an unmapped place
        check("mode_port", {4'h0, cmp_a_mode}, 8'h02);
        rd(8'h9b, 8'h00);
        rd(8'h9a, 8'h00);
        rd(8'h9d, 8'h82);
        wr(8'h9c, 8'hff);
        rd(8'h9c, 8'h00);
        // Every response code, unused bits written as ones
        for (int i = 0; i < 4; i++)
        begin
            rie_fie = 2'($urandom());
            wr(8'h9d, {2'b11, rie_fie, 2'b11, i[1:0]});
            check("mode_port", {4'h0, cmp_a_mode}, {4'h0, rie_fie, i[1:0]});
            rd(8'h9d, {2'b10, rie_fie, 2'b00, i[1:0]});
        end
        // Every hysteresis code on both channels, output bit written as one
        for (int i = 0; i < 4; i++)
        begin
            hy = 2'($urandom());
            wr(8'h9b, {4'h4, i[1:0], hy});
            wr(8'h9a, {4'h4, hy, i[1:0]});
            check("ctrl_a", {3'h0, cmp_a_ctrl}, {4'h0, i[1:0], hy});
            check("ctrl_b", {3'h0, cmp_b_ctrl}, {4'h0, hy, i[1:0]});
            rd(8'h9b, {4'h0, i[1:0], hy});
            rd(8'h9a, {4'h0, hy, i[1:0]});
        end
        // Disabled comparators ignore a high input
        wr(8'h9b, 8'h00);
        wr(8'h9a, 8'h00);
        wr(8'h9d, 8'h80);
        cmp_a_raw = 1'b1;
        cmp_b_raw = 1'b1;
        wait_n(5);
        check("sync_a_off", {7'h0, cmp_a_sync_out}, 8'h00);
        check("sync_b_off", {7'h0, cmp_b_sync_out}, 8'h00);
        rd(8'h9b, 8'h00);
        // Enable A with input high: edge seen on power up, then cleared
        wr(8'h9d, 8'ha0);
        wr(8'h9b, 8'h80);
        check("irq_power_on", {7'h0, cmp_irq}, 8'h01);
        rd(8'h9b, 8'he0);
        wr(8'h9b, 8'h80);
        rd(8'h9b, 8'hc0);
        check("irq_idle", {7'h0, cmp_irq}, 8'h00);
        step_a(1'b0);
        check("irq_fall_masked", {7'h0, cmp_irq}, 8'h00);
        rd(8'h9b, 8'h90);
        wr(8'h9d, 8'h90);
        check("irq_fall", {7'h0, cmp_irq}, 8'h01);
        step_a(1'b1);
        wr(8'h9b, 8'ha0);
        check("irq_rise_masked", {7'h0, cmp_irq}, 8'h00);
        rd(8'h9b, 8'he0);
        wr(8'h9d, 8'ha0);
        check("irq_rise", {7'h0, cmp_irq}, 8'h01);
        wr(8'h9b, 8'h80);
        check("irq_clear", {7'h0, cmp_irq}, 8'h00);
        // Disabling a high comparator drops its output
        wr(8'h9b, 8'h00);
        check("sync_a_dis", {7'h0, cmp_a_sync_out}, 8'h00);
        rd(8'h9b, 8'h10);
        check("irq_fall_off", {7'h0, cmp_irq}, 8'h00);
        wr(8'h9b, 8'h00);
        // Second channel, its flags never reach the request line
        wr(8'h9a, 8'h80);
        rd(8'h9a, 8'he0);
        check("sync_b_on", {7'h0, cmp_b_sync_out}, 8'h01);
        check("irq_b", {7'h0, cmp_irq}, 8'h00);
        cmp_b_raw = 1'b0;
        wait_n(4);
        rd(8'h9a, 8'hb0);
        for (int i = 0; i < 8; i++)
        begin
            v = 1'($urandom());
            cmp_b_raw = v;
            wait_n(4);
            check("sync_b", {7'h0, cmp_b_sync_out}, {7'h0, v});
        end
        wait_n(2);
        stop_test();
    end

endmodule : testbench

`default_nettype wire
